// ==== ftlc_buf.sv ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module ftlc_buf #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  logic [W-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_data_out = mem_r[rd_ptr_r];

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push) mem_r[wr_ptr_r] <= in_data_in;
  end

  buf_bound_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cnt_r == 2'h2 && !out_ready_in |=> cnt_r == 2'h2)
    else $error("Full buffer lost a word while stalled.");
endmodule : ftlc_buf

// ==== ftlc_coder.sv ====
// Fast Ethernet transmit line coder: 4B5B encoder, serializer and receive decoder.
`timescale 1ns/1ps
module ftlc_coder (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // MAC transmit nibbles
  input wire logic mac_tx_valid_in,
  output logic mac_tx_ready_out,
  input wire logic mac_tx_en_in,
  input wire logic [3:0] mac_txd_in,
  // Straps and analog status
  input wire logic [4:0] phy_address_straps_in,
  input wire logic energy_in,
  output logic signal_detect_out,
  // Line side
  output logic line_pos_out,
  output logic line_neg_out,
  output logic line_nrzi_out,
  output logic [1:0] loopback_mlt_out,
  output logic line_bit_valid_out,
  // Receive code-groups
  input wire logic rx_code_valid_in,
  input wire logic [4:0] rx_code_in,
  output logic rx_nibble_valid_out,
  output logic [3:0] rx_nibble_out,
  output logic rx_halt_out,
  output logic rx_invalid_out
);
  import ftlc_pkg::*;

  // ==========================================================================
  // Strap capture
  // Straps are caught after reset release, never as a reset value.
  logic [4:0] strap_s1_r;
  logic [4:0] strap_s2_r;
  logic [1:0] seed_cnt_r;
  logic seeded_r;
  wire seed_load = !seeded_r && (seed_cnt_r == SEED_WAIT);
  wire [LFSR_W-1:0] seed_val = {strap_s2_r, SEED_LOW};

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_s1_r <= 5'h0_0;
      strap_s2_r <= 5'h0_0;
      seed_cnt_r <= 2'h0;
      seeded_r <= 1'b0;
    end else begin
      strap_s1_r <= phy_address_straps_in;
      strap_s2_r <= strap_s1_r;
      if (!seeded_r) seed_cnt_r <= seed_cnt_r + 2'h1;
      if (seed_load) seeded_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Input buffer
  logic buf_valid;
  logic buf_ready;
  logic [4:0] buf_data;
  wire buf_en = buf_data[4];
  wire [3:0] buf_nib = buf_data[3:0];

  ftlc_buf #(.W(5)) u_buf (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(mac_tx_valid_in),
    .in_ready_out(mac_tx_ready_out),
    .in_data_in({mac_tx_en_in, mac_txd_in}),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_ready),
    .out_data_out(buf_data)
  );

  // ==========================================================================
  // Encoder state machine and serializer
  ftlc_state_t state_r;
  ftlc_state_t state_nxt;
  logic [2:0] bit_cnt_r;
  logic [4:0] sh_r;
  logic [4:0] code_nxt;
  logic pop_sel;
  wire sym_tick = seeded_r && (bit_cnt_r == SYM_LAST);
  wire frame_nib = buf_valid && buf_en;
  wire frame_end = buf_valid && !buf_en;

  always_comb begin
    state_nxt = state_r;
    code_nxt = CG_IDLE;
    pop_sel = 1'b0;
    case (state_r)
      FTLC_IDLE, FTLC_R: begin
        if (state_r == FTLC_IDLE && frame_nib) begin
          state_nxt = FTLC_J;
          code_nxt = CG_J;
          pop_sel = 1'b1;
        end else begin
          state_nxt = FTLC_IDLE;
          code_nxt = CG_IDLE;
          pop_sel = (state_r == FTLC_IDLE) && frame_end;
        end
      end
      FTLC_J: begin
        state_nxt = FTLC_K;
        code_nxt = CG_K;
        pop_sel = buf_valid;
      end
      FTLC_K, FTLC_DATA: begin
        if (frame_nib) begin
          state_nxt = FTLC_DATA;
          code_nxt = ftlc_enc(buf_nib);
          pop_sel = 1'b1;
        end else if (frame_end) begin
          state_nxt = FTLC_T;
          code_nxt = CG_T;
        end else begin
          // A starved frame is marked bad rather than stretched silently.
          state_nxt = FTLC_DATA;
          code_nxt = CG_HALT;
        end
      end
      FTLC_T: begin
        state_nxt = FTLC_R;
        code_nxt = CG_R;
      end
      default: begin
        state_nxt = FTLC_IDLE;
        code_nxt = CG_IDLE;
      end
    endcase
  end

  assign buf_ready = sym_tick && pop_sel;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= FTLC_IDLE;
      bit_cnt_r <= 3'h0;
      sh_r <= CG_IDLE;
    end else if (seeded_r) begin
      bit_cnt_r <= sym_tick ? 3'h0 : bit_cnt_r + 3'h1;
      if (sym_tick) begin
        state_r <= state_nxt;
        sh_r <= code_nxt;
      end else begin
        sh_r <= {sh_r[3:0], 1'b0};
      end
    end
  end

  ftlc_line u_line (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .seed_load_in(seed_load),
    .seed_in(seed_val),
    .bit_en_in(seeded_r),
    .nrz_bit_in(sh_r[4]),
    .nrzi_out(line_nrzi_out),
    .pos_out(line_pos_out),
    .neg_out(line_neg_out),
    .mlt_out(loopback_mlt_out)
  );
  assign line_bit_valid_out = seeded_r;

  // ==========================================================================
  // Receive decoder
  wire [5:0] dec_res = ftlc_dec(rx_code_in);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_nibble_valid_out <= 1'b0;
      rx_nibble_out <= 4'h0;
      rx_halt_out <= 1'b0;
      rx_invalid_out <= 1'b0;
    end else begin
      rx_nibble_valid_out <= rx_code_valid_in;
      if (rx_code_valid_in) begin
        rx_nibble_out <= dec_res[3:0];
        rx_halt_out <= dec_res[4];
        rx_invalid_out <= dec_res[5];
      end
    end
  end

  // ==========================================================================
  // Signal detect qualifier
  // Link pulses are far shorter than the qualifying time, so they never count.
  logic energy_s1_r;
  logic energy_s2_r;
  logic [7:0] sd_cnt_r;
  logic sd_r;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      energy_s1_r <= 1'b0;
      energy_s2_r <= 1'b0;
      sd_cnt_r <= 8'h00;
      sd_r <= 1'b0;
    end else begin
      energy_s1_r <= energy_in;
      energy_s2_r <= energy_s1_r;
      if (!energy_s2_r) sd_cnt_r <= 8'h00;
      else if (sd_cnt_r != 8'(SD_QUAL_CYC)) sd_cnt_r <= sd_cnt_r + 8'h01;
      sd_r <= energy_s2_r && (sd_cnt_r == 8'(SD_QUAL_CYC));
    end
  end
  assign signal_detect_out = sd_r;

  // ==========================================================================
  // Checks
  sequence tick_in(ftlc_state_t s);
    sym_tick && state_r == s;
  endsequence
  sequence next_sym;
    !sym_tick [*4] ##1 sym_tick;
  endsequence

  start_j_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tick_in(FTLC_IDLE) ##0 frame_nib |=> sh_r == CG_J ##0 next_sym ##1 sh_r == CG_K)
    else $error("Frame start did not send J then K.");
  data_map_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sym_tick && (state_r == FTLC_K || state_r == FTLC_DATA) && frame_nib
      |=> sh_r == ftlc_enc($past(buf_nib)) && buf_ready == 1'b0)
    else $error("Data nibble sent with the wrong code-group.");
  data_high_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sym_tick && state_r == FTLC_DATA && frame_nib && buf_nib[3] |=> sh_r[4] || sh_r[3])
    else $error("Upper nibble gave a code-group from the low table.");
  end_tr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tick_in(FTLC_DATA) ##0 frame_end |=> sh_r == CG_T ##0 next_sym ##1 sh_r == CG_R)
    else $error("Frame end did not send T then R.");
  idle_fill_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tick_in(FTLC_R) |=> sh_r == CG_IDLE && state_r == FTLC_IDLE)
    else $error("Idle did not follow the end delimiter.");
  sym_period_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sym_tick |-> ##1 next_sym)
    else $error("Code-group period is not five bit times.");
  rx_halt_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_code_valid_in && rx_code_in == CG_HALT |=> rx_halt_out && !rx_invalid_out)
    else $error("Halt code-group not flagged.");
  rx_jk_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_code_valid_in && (rx_code_in == CG_J || rx_code_in == CG_K)
      |=> rx_nibble_out == NIB_JK && !rx_invalid_out)
    else $error("J or K did not decode to the preamble nibble.");
  sd_pulse_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !energy_s2_r |=> !sd_r [*2])
    else $error("Signal detect rose without sustained energy.");

  // ==========================================================================
  // Underrun, idle and receive decode checks
  // A starved frame must be visibly broken on the line, never padded with stale data.
  underrun_halt_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tick_in(FTLC_DATA) ##0 !buf_valid |=> sh_r == CG_HALT)
    else $error("Underrun did not send the halt code-group.");
  idle_wait_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tick_in(FTLC_IDLE) ##0 !frame_nib |=> sh_r == CG_IDLE)
    else $error("Idle line did not carry the idle code-group.");
  rx_invalid_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_code_valid_in && rx_code_in == 5'h00 |=> rx_invalid_out && !rx_halt_out)
    else $error("Invalid code-group not flagged.");
  rx_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_code_valid_in && rx_code_in == 5'h1E |=> rx_nibble_out == 4'h0 && !rx_invalid_out)
    else $error("Data code-group zero decoded wrongly.");
  rx_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_code_valid_in && rx_code_in == CG_IDLE |=> rx_nibble_out == NIB_CTRL && !rx_halt_out)
    else $error("Idle code-group did not decode to the control nibble.");
endmodule : ftlc_coder

// ==== ftlc_coder_bench.sv ====
// Self-checking bench for the transmit line coder and its receive decoder.
`timescale 1ns/1ps
module ftlc_coder_bench;
  import ftlc_pkg::*;
  // ==========================================================================
  // Signals
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic mac_valid;
  logic mac_ready;
  logic mac_en;
  logic [3:0] mac_txd;
  logic [4:0] straps = 5'h13;
  logic energy = 1'b0;
  logic sig_det;
  logic line_pos;
  logic line_neg;
  logic line_nrzi;
  logic [1:0] loop_mlt;
  logic line_ok;
  logic rx_valid = 1'b0;
  logic [4:0] rx_code = 5'h00;
  logic rx_nib_valid;
  logic [3:0] rx_nib;
  logic rx_halt;
  logic rx_inval;
  int fails = 0;
  int total_checks = 0;
  int refused = 0;
  localparam logic [4:0] ENC_TAB [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  always #50 core_clk_in = ~core_clk_in;

  ftlc_mac_model u_mac (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .mac_tx_ready_in(mac_ready), .mac_tx_valid_out(mac_valid), .mac_tx_en_out(mac_en),
    .mac_txd_out(mac_txd));

  ftlc_coder u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .mac_tx_valid_in(mac_valid), .mac_tx_ready_out(mac_ready), .mac_tx_en_in(mac_en),
    .mac_txd_in(mac_txd), .phy_address_straps_in(straps), .energy_in(energy),
    .signal_detect_out(sig_det), .line_pos_out(line_pos), .line_neg_out(line_neg),
    .line_nrzi_out(line_nrzi), .loopback_mlt_out(loop_mlt), .line_bit_valid_out(line_ok),
    .rx_code_valid_in(rx_valid), .rx_code_in(rx_code), .rx_nibble_valid_out(rx_nib_valid),
    .rx_nibble_out(rx_nib), .rx_halt_out(rx_halt), .rx_invalid_out(rx_inval));

  // ==========================================================================
  // Reporting
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Line monitor
  // The descrambler trains on the idle stream, so it does not depend on when the seed loads.
  logic nrzi_p = 1'b0;
  logic [1:0] mlt_p = 2'h0;
  logic [1:0] mlt_last = 2'h0;
  logic [10:0] key_h = 11'h000;
  int line_n = 0;
  logic bit_q[$];
  always @(negedge core_clk_in) begin
    logic b;
    logic k;
    if (mac_valid && !mac_ready) begin
      refused++;
    end
    if (rst_n_in && line_ok) begin
      b = line_nrzi ^ nrzi_p;
      chk("pos_side", line_pos, loop_mlt == MLT_POS);
      chk("neg_side", line_neg, loop_mlt == MLT_NEG);
      chk("mlt_step", loop_mlt != mlt_p, b);
      if (loop_mlt != mlt_p && loop_mlt != MLT_ZERO) begin
        chk("mlt_alternate", loop_mlt != mlt_last, 1'b1);
        mlt_last = loop_mlt;
      end
      k = (line_n < 40) ? ~b : key_h[10] ^ key_h[8];
      key_h = {key_h[9:0], k};
      if (line_n >= 40) begin
        bit_q.push_back(b ^ k);
      end
      line_n++;
      nrzi_p = line_nrzi;
      mlt_p = loop_mlt;
    end
  end

  task automatic pop_bit(output logic b);
    int n;
    n = 0;
    while (bit_q.size() == 0 && n < 400) begin
      @(posedge core_clk_in);
      n++;
    end
    if (bit_q.size() == 0) begin
      chk("line_bits_timeout", 8'h00, 8'h01);
      close_out();
    end else begin
      b = bit_q.pop_front();
    end
  endtask : pop_bit

  task automatic get_code(output logic [4:0] cg);
    for (int i = 4; i >= 0; i--) begin
      pop_bit(cg[i]);
    end
  endtask : get_code

  // ==========================================================================
  // Scenarios
  // Frame of four preamble nibbles and sixteen data nibbles, pushed back to back.
  task automatic run_frame(input logic [3:0] base);
    logic [9:0] win;
    logic [4:0] cg;
    logic [3:0] nib;
    logic b;
    int n;
    while (bit_q.size() > 0) begin
      chk("idle_bit", bit_q.pop_front(), 1'b1);
    end
    refused = 0;
    for (int i = 0; i < 20; i++) begin
      nib = (i < 4) ? 4'h5 : base + 4'(i - 4);
      u_mac.push(1'b1, nib);
    end
    u_mac.push(1'b0, 4'h0);
    win = 10'h3FF;
    n = 0;
    while (win[4:0] != CG_J && n < 400) begin
      pop_bit(b);
      win = {win[8:0], b};
      n++;
    end
    chk("idle_before_start", win[9:5], CG_IDLE);
    chk("start_j", win[4:0], CG_J);
    get_code(cg);
    chk("start_k", cg, CG_K);
    for (int i = 2; i < 20; i++) begin
      nib = (i < 4) ? 4'h5 : base + 4'(i - 4);
      get_code(cg);
      chk("data_code", cg, ENC_TAB[nib]);
    end
    get_code(cg);
    chk("end_t", cg, CG_T);
    get_code(cg);
    chk("end_r", cg, CG_R);
    repeat (3) begin
      get_code(cg);
      chk("idle_fill", cg, CG_IDLE);
    end
    chk("buffer_refused", refused > 0, 1'b1);
  endtask : run_frame

  function automatic logic [5:0] exp_dec(input logic [4:0] c);
    exp_dec = 6'h20;
    for (int i = 0; i < 16; i++) begin
      if (ENC_TAB[i] == c) begin
        exp_dec = {2'b00, 4'(i)};
      end
    end
    if (c == CG_J || c == CG_K) begin
      exp_dec = {2'b00, NIB_JK};
    end
    if (c == CG_IDLE || c == CG_T || c == CG_R) begin
      exp_dec = {2'b00, NIB_CTRL};
    end
    if (c == CG_HALT) begin
      exp_dec = {2'b01, NIB_CTRL};
    end
  endfunction : exp_dec

  // All thirty-two patterns back to back; each answer is read at the falling edge after it lands.
  task automatic rx_decode;
    for (int k = 0; k < 33; k++) begin
      @(posedge core_clk_in);
      rx_valid <= (k < 32);
      rx_code <= 5'(k);
      @(negedge core_clk_in);
      if (k >= 1) begin
        chk("rx_valid", rx_nib_valid, 1'b1);
        chk("rx_result", {rx_inval, rx_halt, rx_nib}, exp_dec(5'(k - 1)));
      end
    end
  endtask : rx_decode

  // Short pulses never qualify; steady energy does, after the qualify time.
  task automatic sig_detect;
    int n;
    repeat (5) begin
      @(posedge core_clk_in);
      energy <= 1'b1;
      @(posedge core_clk_in);
      energy <= 1'b0;
      repeat (14) begin
        @(negedge core_clk_in);
        chk("sd_on_pulse", sig_det, 1'b0);
      end
    end
    @(posedge core_clk_in);
    energy <= 1'b1;
    n = 0;
    while (sig_det !== 1'b1 && n < 40) begin
      @(negedge core_clk_in);
      n++;
    end
    chk("sd_rise_time", n >= SD_QUAL_CYC && n < SD_QUAL_CYC + 8, 1'b1);
    @(posedge core_clk_in);
    energy <= 1'b0;
    n = 0;
    while (sig_det !== 1'b0 && n < 10) begin
      @(negedge core_clk_in);
      n++;
    end
    chk("sd_fall_time", n < 6, 1'b1);
  endtask : sig_detect

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (60) @(posedge core_clk_in);
    rx_decode();
    sig_detect();
    run_frame(4'h0);
    run_frame(4'h9);
    close_out();
  end
endmodule : ftlc_coder_bench

// ==== ftlc_line.sv ====
// Scrambler, NRZI encoder and MLT-3 splitter for the serial line stream.
`timescale 1ns/1ps
module ftlc_line (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Seed and serial input
  input wire logic seed_load_in,
  input wire logic [ftlc_pkg::LFSR_W-1:0] seed_in,
  input wire logic bit_en_in,
  input wire logic nrz_bit_in,
  // Line side
  output logic nrzi_out,
  output logic pos_out,
  output logic neg_out,
  output logic [1:0] mlt_out
);
  import ftlc_pkg::*;

  logic [LFSR_W-1:0] lfsr_r;
  logic nrzi_r;
  logic [1:0] mlt_r;
  logic last_pos_r;

  // ==========================================================================
  // Scrambler and NRZI
  wire key_bit = lfsr_r[LFSR_W-1];
  wire fb_bit = lfsr_r[LFSR_W-1] ^ lfsr_r[LFSR_TAP];
  wire scr_bit = nrz_bit_in ^ key_bit;
  wire [1:0] mlt_nxt = (mlt_r != MLT_ZERO) ? MLT_ZERO : (last_pos_r ? MLT_NEG : MLT_POS);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lfsr_r <= '1;
      nrzi_r <= 1'b0;
      mlt_r <= MLT_ZERO;
      last_pos_r <= 1'b0;
    end else if (seed_load_in) begin
      lfsr_r <= seed_in;
    end else if (bit_en_in) begin
      lfsr_r <= {lfsr_r[LFSR_W-2:0], fb_bit};
      // The NRZI stage has no bypass path at all.
      if (scr_bit) nrzi_r <= ~nrzi_r;
      if (scr_bit) mlt_r <= mlt_nxt;
      if (scr_bit && mlt_r == MLT_ZERO) last_pos_r <= ~last_pos_r;
    end
  end

  assign nrzi_out = nrzi_r;
  assign mlt_out = mlt_r;
  // Only MLT-3 leaves on the pair; each side carries alternate ones.
  assign pos_out = (mlt_r == MLT_POS);
  assign neg_out = (mlt_r == MLT_NEG);

  nrzi_toggle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    bit_en_in && !seed_load_in |=> nrzi_r == ($past(nrzi_r) ^ $past(scr_bit)))
    else $error("NRZI level did not follow the scrambled bit.");
  mlt_alt_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(pos_out) |-> !neg_out ##0 (last_pos_r))
    else $error("MLT-3 ones did not alternate between the two sides.");
  scram_xor_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    bit_en_in && !seed_load_in && scr_bit != nrz_bit_in |-> key_bit)
    else $error("Scrambled bit differs from data without a key bit.");
endmodule : ftlc_line

// ==== ftlc_mac_model.sv ====
// Behavioural MAC that offers transmit nibbles through valid and ready.
`timescale 1ns/1ps
module ftlc_mac_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Nibble handshake
  input wire logic mac_tx_ready_in,
  output logic mac_tx_valid_out,
  output logic mac_tx_en_out,
  output logic [3:0] mac_txd_out
);
  logic [4:0] pend_q[$];
  // ==========================================================================
  // Entry queue
  task automatic push(input logic en, input logic [3:0] nib);
    pend_q.push_back({en, nib});
  endtask : push
  // ==========================================================================
  // Offer logic
  // An offer holds until ready is seen; an idle bus shows flipped data so nothing stale matches.
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mac_tx_valid_out <= 1'b0;
      mac_tx_en_out <= 1'b0;
      mac_txd_out <= 4'h0;
    end else if (!mac_tx_valid_out || mac_tx_ready_in) begin
      if (pend_q.size() > 0) begin
        {mac_tx_en_out, mac_txd_out} <= pend_q.pop_front();
        mac_tx_valid_out <= 1'b1;
      end else begin
        mac_tx_valid_out <= 1'b0;
        mac_txd_out <= ~mac_txd_out;
      end
    end
  end
endmodule : ftlc_mac_model

// ==== ftlc_pkg.sv ====
// Shared constants, code-group table and coder functions for the line coder.
package ftlc_pkg;

  // ==========================================================================
  // Code-groups
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;
  localparam logic [3:0] NIB_JK = 4'h5;
  localparam logic [3:0] NIB_CTRL = 4'h0;

  // ==========================================================================
  // Serializer, scrambler and reset values
  localparam int SYM_BITS = 5;
  localparam logic [2:0] SYM_LAST = 3'h4;
  localparam int LFSR_W = 11;
  localparam int LFSR_TAP = 8;
  localparam logic [5:0] SEED_LOW = 6'h01;
  localparam logic [1:0] SEED_WAIT = 2'h3;
  localparam logic [1:0] MLT_ZERO = 2'h0;
  localparam logic [1:0] MLT_POS = 2'h1;
  localparam logic [1:0] MLT_NEG = 2'h3;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SD_QUAL_NS = 1000;
  localparam int SD_QUAL_CYC = (SD_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    FTLC_IDLE = 3'b000,
    FTLC_J = 3'b001,
    FTLC_K = 3'b010,
    FTLC_DATA = 3'b011,
    FTLC_T = 3'b100,
    FTLC_R = 3'b101
  } ftlc_state_t;

  function automatic logic [4:0] ftlc_enc(input logic [3:0] nib);
    logic [4:0] cg;
    cg = CG_HALT;
    case (nib)
      4'h0: cg = 5'h1E;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0A;
      4'h5: cg = 5'h0B;
      4'h6: cg = 5'h0E;
      4'h7: cg = 5'h0F;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'hA: cg = 5'h16;
      4'hB: cg = 5'h17;
      4'hC: cg = 5'h1A;
      4'hD: cg = 5'h1B;
      4'hE: cg = 5'h1C;
      default: cg = 5'h1D;
    endcase
    return cg;
  endfunction : ftlc_enc

  // Result is {invalid, halt, nibble}.
  function automatic logic [5:0] ftlc_dec(input logic [4:0] cg);
    logic [5:0] r;
    r = {2'b10, NIB_CTRL};
    case (cg)
      5'h1E: r = {2'b00, 4'h0};
      5'h09: r = {2'b00, 4'h1};
      5'h14: r = {2'b00, 4'h2};
      5'h15: r = {2'b00, 4'h3};
      5'h0A: r = {2'b00, 4'h4};
      5'h0B: r = {2'b00, 4'h5};
      5'h0E: r = {2'b00, 4'h6};
      5'h0F: r = {2'b00, 4'h7};
      5'h12: r = {2'b00, 4'h8};
      5'h13: r = {2'b00, 4'h9};
      5'h16: r = {2'b00, 4'hA};
      5'h17: r = {2'b00, 4'hB};
      5'h1A: r = {2'b00, 4'hC};
      5'h1B: r = {2'b00, 4'hD};
      5'h1C: r = {2'b00, 4'hE};
      5'h1D: r = {2'b00, 4'hF};
      CG_J, CG_K: r = {2'b00, NIB_JK};
      CG_IDLE, CG_T, CG_R: r = {2'b00, NIB_CTRL};
      CG_HALT: r = {2'b01, NIB_CTRL};
      default: r = {2'b10, NIB_CTRL};
    endcase
    return r;
  endfunction : ftlc_dec

endpackage : ftlc_pkg
